// file: hw/pin_sync.sv
/*
  two-flop synchroniser for a group of pins.
  assumes inputs asynchronous to core_clk.
*/
`timescale 1ns/100ps
module pin_sync #(parameter int W = 8) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] meta_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      pin_out <= '0;
    end else begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end
endmodule : pin_sync

// file: hw/ppp_defines.svh
/*
  constants for the parallel programming port: command codes, selects,
  page geometry and timing counts.
  assumes a 100 MHz core clock on both ends.
*/
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EEP 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EEP 8'h03
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define BSEL_LO 2'h0
`define BSEL_HI 2'h1
`define BSEL_EXT 2'h2
`define BSEL_TOP 2'h3
`define FLASH_WORDS 64
`define EEP_BYTES 4
`define FUSE_LO_RST 8'h5e
`define FUSE_HI_RST 8'hd9
`define FUSE_EXT_RST 8'hf4
`define LOCK_RST 8'hff
`define KEEP_EEP_BIT 3
`define CLK_MHZ 100
`define ENTRY_HOLD_NS 100
`define ENTRY_HOLD_CYC ((`ENTRY_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define FIRST_CMD_US 50
`define FIRST_CMD_CYC (`FIRST_CMD_US * `CLK_MHZ)
`define MIN_LOAD_TOGGLES 6
`define PULSE_NS 250
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define BUSY_CYC 64
`endif

// file: hw/ppp_device.sv
/*
  device end of the parallel programming port: entry check, load decode,
  page buffers, command execution and read-back on the data bus.
  assumes a programmer on ppp_if; pins are synchronised here first.
*/
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "ppp_defines.svh"
// Overview of operation
// - ready_busy_n low while erase or write runs
// - drive data bus only when output enable low
// - address load byte select picks low/high/extended
// - fuse byte select for writes and reads
// - action bits choose address, data, command, idle
// - byte_select_lo picks flash data high byte
// - decode the nine command bytes
// - programmer toggles load_clock six times under reset
// - programmer holds entry pins zero before voltage
// - entry fails if pins move after voltage
// - programmer waits 50 us before first command
// - command and address kept until reloaded
// - reload high address only on new window
// - erase clears flash, eeprom and locks in the same cycle
// - erase keeps fuse bits
// - keep_eeprom_fuse protects eeprom from erase
// - write strobe after erase command starts erase
// - programmer erases before reprogramming memories
// - page latch copies data word into buffer
// - flash buffer 64 words, page from upper bits
// - eeprom buffer 4 bytes, page from upper bits
// - low address upper bits give page number
// - write strobe with select 00 programs page
module ppp_device (
  input wire logic core_clk,
  input wire logic sys_rst,
  ppp_if.device pins,
  output logic in_prog_mode,
  output logic erase_done,
  output logic [12:0] last_flash_page_addr
);
  import ppp_pkg::*;
  typedef enum {ST_OFF, ST_ARM, ST_RUN, ST_BUSY} dev_state_t;
  logic [15:0] raw;
  logic [15:0] s;
  assign raw = {pins.data_bus, pins.load_clock, pins.action_bit0,
    pins.action_bit1, pins.byte_select_lo, pins.byte_select_hi,
    pins.page_latch_strobe, pins.program_strobe_n, pins.output_enable_n};
  pin_sync #(.W(16)) u_sync (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(raw), .pin_out(s));
  logic hv_meta_r, hv_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hv_meta_r <= 1'b0;
      hv_r <= 1'b0;
    end else begin
      hv_meta_r <= pins.prog_voltage;
      hv_r <= hv_meta_r;
    end
  end
  byte_t d;
  logic lclk, oe_n, wr_n, pgl;
  sel_t act, bsel;
  assign d = s[15:8];
  assign lclk = s[7];
  assign act = {s[5], s[6]};
  assign bsel = {s[3], s[4]};
  assign pgl = s[2];
  assign wr_n = s[1];
  assign oe_n = s[0];
  logic [3:0] entry;
  assign entry = {pgl, act, s[4]};

  dev_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic lclk_q_r, pgl_q_r, wr_q_r;
  byte_t cmd_r, cmd_nxt;
  logic [23:0] addr_r, addr_nxt;
  byte_t dlo_r, dlo_nxt, dhi_r, dhi_nxt;
  byte_t fuse_r [4];
  byte_t fuse_nxt [4];
  logic [15:0] fbuf_r [`FLASH_WORDS];
  logic [15:0] fbuf_nxt [`FLASH_WORDS];
  byte_t ebuf_r [`EEP_BYTES];
  byte_t ebuf_nxt [`EEP_BYTES];
  logic erase_eep_r, erase_eep_nxt, erase_run_r, erase_run_nxt;
  logic done_nxt;
  logic [12:0] fpage_nxt;
  logic lclk_rise, pgl_rise, wr_fall;
  assign lclk_rise = lclk & ~lclk_q_r;
  assign pgl_rise = pgl & ~pgl_q_r;
  assign wr_fall = ~wr_n & wr_q_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    dlo_nxt = dlo_r;
    dhi_nxt = dhi_r;
    fuse_nxt = fuse_r;
    fbuf_nxt = fbuf_r;
    ebuf_nxt = ebuf_r;
    erase_eep_nxt = erase_eep_r;
    erase_run_nxt = erase_run_r;
    done_nxt = 1'b0;
    fpage_nxt = last_flash_page_addr;
    case (st_r)
      ST_OFF: begin
        cnt_nxt = '0;
        if (hv_r && entry == 4'h0) st_nxt = ST_ARM;
      end
      ST_ARM: begin
        if (!hv_r) st_nxt = ST_OFF;
        else if (entry != 4'h0) st_nxt = ST_OFF;
        else if (cnt_r == 8'(`ENTRY_HOLD_CYC)) st_nxt = ST_RUN;
        else cnt_nxt = cnt_r + 8'h01;
      end
      ST_RUN: begin
        if (!hv_r) st_nxt = ST_OFF;
        else if (lclk_rise) begin
          case (act)
            `ACT_ADDR: begin
              case (bsel)
                `BSEL_LO: addr_nxt[7:0] = d;
                `BSEL_HI: addr_nxt[15:8] = d;
                `BSEL_EXT: addr_nxt[23:16] = d;
                default: ;
              endcase
            end
            `ACT_DATA: begin
              if (bsel[0]) dhi_nxt = d;
              else dlo_nxt = d;
            end
            `ACT_CMD: cmd_nxt = d;
            default: ;
          endcase
        end else if (pgl_rise) begin
          if (cmd_r == `CMD_WR_FLASH)
            fbuf_nxt[addr_r[5:0]] = {dhi_r, dlo_r};
          else if (cmd_r == `CMD_WR_EEP)
            ebuf_nxt[addr_r[1:0]] = dlo_r;
        end else if (wr_fall) begin
          cnt_nxt = '0;
          case (cmd_r)
            `CMD_ERASE: begin
              st_nxt = ST_BUSY;
              erase_run_nxt = 1'b1;
              // keep flag read live: it acts once programmed
              erase_eep_nxt = fuse_r[1][`KEEP_EEP_BIT];
            end
            `CMD_WR_FUSE: begin
              st_nxt = ST_BUSY;
              case (bsel)
                `BSEL_LO: fuse_nxt[0] = dlo_r;
                `BSEL_HI: fuse_nxt[1] = dlo_r;
                `BSEL_EXT: fuse_nxt[2] = dlo_r;
                default: ;
              endcase
            end
            `CMD_WR_LOCK: begin
              st_nxt = ST_BUSY;
              fuse_nxt[3] = fuse_r[3] & dlo_r;
            end
            `CMD_WR_FLASH, `CMD_WR_EEP: begin
              if (bsel == `BSEL_LO) begin
                st_nxt = ST_BUSY;
                fpage_nxt = (cmd_r == `CMD_WR_EEP) ?
                  {4'h0, addr_r[8:2], 2'h0} : {addr_r[12:6], 6'h00};
              end
            end
            default: ;
          endcase
        end
      end
      ST_BUSY: begin
        if (cnt_r == 8'(`BUSY_CYC)) begin
          st_nxt = ST_RUN;
          if (erase_run_r) begin
            // locks released in the same cycle as the memory erase
            fuse_nxt[3] = `LOCK_RST;
            erase_run_nxt = 1'b0;
            done_nxt = 1'b1;
            for (int i = 0; i < `FLASH_WORDS; i++) begin
              fbuf_nxt[i] = 16'hffff;
            end
            if (erase_eep_r) begin
              for (int i = 0; i < `EEP_BYTES; i++) begin
                ebuf_nxt[i] = 8'hff;
              end
            end
          end
        end else cnt_nxt = cnt_r + 8'h01;
      end
      default: st_nxt = ST_OFF;
    endcase
  end

  byte_t rd_nxt;
  logic oe_nxt;
  always_comb begin
    rd_nxt = 8'hff;
    oe_nxt = (st_r == ST_RUN || st_r == ST_BUSY) && !oe_n;
    case (cmd_r)
      `CMD_RD_FLASH: rd_nxt = bsel[0] ? fbuf_r[addr_r[5:0]][15:8] :
                                        fbuf_r[addr_r[5:0]][7:0];
      `CMD_RD_EEP: rd_nxt = ebuf_r[addr_r[1:0]];
      `CMD_RD_FUSE: begin
        case (bsel)
          `BSEL_LO: rd_nxt = fuse_r[0];
          `BSEL_HI: rd_nxt = fuse_r[3];
          `BSEL_EXT: rd_nxt = fuse_r[2];
          default: rd_nxt = fuse_r[1];
        endcase
      end
      `CMD_RD_SIG: rd_nxt = {6'h00, addr_r[1:0]};
      default: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= ST_OFF;
      cnt_r <= '0;
      lclk_q_r <= 1'b0;
      pgl_q_r <= 1'b0;
      // synchroniser clears to 0, so match it: no false strobe fall
      wr_q_r <= 1'b0;
      cmd_r <= `CMD_NOP;
      addr_r <= '0;
      dlo_r <= '0;
      dhi_r <= '0;
      fuse_r[0] <= `FUSE_LO_RST;
      fuse_r[1] <= `FUSE_HI_RST;
      fuse_r[2] <= `FUSE_EXT_RST;
      fuse_r[3] <= `LOCK_RST;
      for (int i = 0; i < `FLASH_WORDS; i++) fbuf_r[i] <= 16'hffff;
      for (int i = 0; i < `EEP_BYTES; i++) ebuf_r[i] <= 8'hff;
      erase_eep_r <= 1'b0;
      erase_run_r <= 1'b0;
      erase_done <= 1'b0;
      last_flash_page_addr <= '0;
      in_prog_mode <= 1'b0;
      pins.ready_busy_n <= 1'b1;
      pins.dev_data_out <= 8'hff;
      pins.dev_data_oe <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lclk_q_r <= lclk;
      pgl_q_r <= pgl;
      wr_q_r <= wr_n;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      dlo_r <= dlo_nxt;
      dhi_r <= dhi_nxt;
      fuse_r <= fuse_nxt;
      fbuf_r <= fbuf_nxt;
      ebuf_r <= ebuf_nxt;
      erase_eep_r <= erase_eep_nxt;
      erase_run_r <= erase_run_nxt;
      erase_done <= done_nxt;
      last_flash_page_addr <= fpage_nxt;
      in_prog_mode <= (st_nxt == ST_RUN) || (st_nxt == ST_BUSY);
      pins.ready_busy_n <= (st_nxt != ST_BUSY);
      pins.dev_data_out <= rd_nxt;
      pins.dev_data_oe <= oe_nxt;
    end
  end
endmodule : ppp_device

// file: hw/ppp_if.sv
/*
  the programming port pins between programmer and device.
  assumes both ends clocked by core_clk; data bus resolved here.
*/
`timescale 1ns/100ps
interface ppp_if;
  logic [7:0] prog_data_out;
  logic prog_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] data_bus;
  logic load_clock;
  logic action_bit0;
  logic action_bit1;
  logic byte_select_lo;
  logic byte_select_hi;
  logic page_latch_strobe;
  logic program_strobe_n;
  logic output_enable_n;
  logic prog_voltage;
  logic ready_busy_n;
  assign data_bus = dev_data_oe ? dev_data_out :
                    (prog_data_oe ? prog_data_out : 8'hff);
  modport device (input data_bus, load_clock, action_bit0, action_bit1,
    byte_select_lo, byte_select_hi, page_latch_strobe, program_strobe_n,
    output_enable_n, prog_voltage, output dev_data_out, dev_data_oe,
    ready_busy_n);
  modport programmer (input data_bus, ready_busy_n, output prog_data_out,
    prog_data_oe, load_clock, action_bit0, action_bit1, byte_select_lo,
    byte_select_hi, page_latch_strobe, program_strobe_n, output_enable_n,
    prog_voltage);
endinterface : ppp_if

// file: hw/ppp_pkg.sv
/*
  types shared by both ends of the programming port.
  assumes ppp_defines.svh for the numbers.
*/
package ppp_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] sel_t;
endpackage : ppp_pkg

// file: hw/ppp_programmer.sv
/*
  programmer end: runs the entry sequence, then plays single pin
  operations ordered through a small register port.
  assumes the device on ppp_if; ready_busy_n and data are synchronised.
*/
`timescale 1ns/100ps
`include "ppp_defines.svh"
module ppp_programmer (
  input wire logic core_clk,
  input wire logic sys_rst,
  ppp_if.programmer pins,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  import ppp_pkg::*;
  typedef enum {P_TOG, P_PAT, P_HV, P_WAIT, P_IDLE, P_SET, P_PULSE,
    P_RBW} prog_state_t;
  typedef enum {OP_LOAD, OP_LATCH, OP_WRITE, OP_READ} op_t;
  logic [8:0] sin;
  logic [8:0] sv;
  assign sin = {pins.data_bus, pins.ready_busy_n};
  pin_sync #(.W(9)) u_sync (.core_clk(core_clk), .sys_rst(sys_rst),
    .pin_in(sin), .pin_out(sv));
  prog_state_t st_r, st_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic [3:0] tog_r, tog_nxt;
  logic [15:0] op_r, op_nxt;
  byte_t rdat_r, rdat_nxt;
  logic [7:0] pout_nxt;
  logic poe_nxt, lclk_nxt, pgl_nxt, wr_n_nxt, oe_n_nxt, hv_nxt;
  sel_t act_nxt, bs_nxt;
  logic busy;
  assign busy = (st_r != P_IDLE);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 13'h0001;
    tog_nxt = tog_r;
    op_nxt = op_r;
    rdat_nxt = rdat_r;
    pout_nxt = op_r[7:0];
    poe_nxt = 1'b0;
    lclk_nxt = 1'b0;
    pgl_nxt = 1'b0;
    wr_n_nxt = 1'b1;
    oe_n_nxt = 1'b1;
    hv_nxt = 1'b1;
    act_nxt = op_r[9:8];
    bs_nxt = op_r[11:10];
    case (st_r)
      P_TOG: begin
        hv_nxt = 1'b0;
        act_nxt = 2'h3;
        lclk_nxt = cnt_r[4];
        if (cnt_r[4:0] == 5'h1f) tog_nxt = tog_r + 4'h1;
        if (tog_r == 4'(`MIN_LOAD_TOGGLES)) begin
          st_nxt = P_PAT;
          cnt_nxt = '0;
        end
      end
      P_PAT: begin
        hv_nxt = 1'b0;
        act_nxt = 2'h0;
        bs_nxt = 2'h0;
        if (cnt_r == 13'(`ENTRY_HOLD_CYC)) begin
          st_nxt = P_HV;
          cnt_nxt = '0;
        end
      end
      P_HV: begin
        act_nxt = 2'h0;
        bs_nxt = 2'h0;
        if (cnt_r == 13'(`ENTRY_HOLD_CYC * 2)) begin
          st_nxt = P_WAIT;
          cnt_nxt = '0;
        end
      end
      P_WAIT: begin
        act_nxt = 2'h3;
        if (cnt_r == 13'(`FIRST_CMD_CYC)) st_nxt = P_IDLE;
      end
      P_IDLE: begin
        act_nxt = 2'h3;
        cnt_nxt = '0;
        if (reg_wr && reg_addr == 2'h0) begin
          op_nxt = reg_wdata;
          st_nxt = P_SET;
        end
      end
      P_SET: begin
        poe_nxt = (op_t'(op_r[13:12]) != OP_READ);
        oe_n_nxt = (op_t'(op_r[13:12]) != OP_READ);
        if (cnt_r == 13'(`PULSE_CYC)) begin
          st_nxt = P_PULSE;
          cnt_nxt = '0;
        end
      end
      P_PULSE: begin
        poe_nxt = (op_t'(op_r[13:12]) != OP_READ);
        oe_n_nxt = (op_t'(op_r[13:12]) != OP_READ);
        case (op_t'(op_r[13:12]))
          OP_LOAD: lclk_nxt = 1'b1;
          OP_LATCH: pgl_nxt = 1'b1;
          OP_WRITE: wr_n_nxt = 1'b0;
          default: rdat_nxt = sv[8:1];
        endcase
        if (cnt_r == 13'(`PULSE_CYC)) begin
          st_nxt = P_RBW;
          cnt_nxt = '0;
        end
      end
      P_RBW: begin
        // device answers busy only after its own sync delay
        if (cnt_r > 13'(`PULSE_CYC) && sv[0]) st_nxt = P_IDLE;
      end
      default: st_nxt = P_TOG;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= P_TOG;
      cnt_r <= '0;
      tog_r <= '0;
      op_r <= '0;
      rdat_r <= '0;
      reg_rdata <= '0;
      pins.prog_data_out <= '0;
      pins.prog_data_oe <= 1'b0;
      pins.load_clock <= 1'b0;
      pins.action_bit0 <= 1'b1;
      pins.action_bit1 <= 1'b1;
      pins.byte_select_lo <= 1'b0;
      pins.byte_select_hi <= 1'b0;
      pins.page_latch_strobe <= 1'b0;
      pins.program_strobe_n <= 1'b1;
      pins.output_enable_n <= 1'b1;
      pins.prog_voltage <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tog_r <= tog_nxt;
      op_r <= op_nxt;
      rdat_r <= rdat_nxt;
      reg_rdata <= !reg_rd ? 16'h0000 :
        (reg_addr == 2'h1 ? {7'h00, busy, rdat_r} : 16'h0000);
      pins.prog_data_out <= pout_nxt;
      pins.prog_data_oe <= poe_nxt;
      pins.load_clock <= lclk_nxt;
      pins.action_bit0 <= act_nxt[0];
      pins.action_bit1 <= act_nxt[1];
      pins.byte_select_lo <= bs_nxt[0];
      pins.byte_select_hi <= bs_nxt[1];
      pins.page_latch_strobe <= pgl_nxt;
      pins.program_strobe_n <= wr_n_nxt;
      pins.output_enable_n <= oe_n_nxt;
      pins.prog_voltage <= hv_nxt;
    end
  end
endmodule : ppp_programmer

// file: sim/ppp_port_sva.sv
/*
  concurrent checks on the programming port wires.
  assumes the pins of ppp_if on core_clk, sync reset sys_rst.
*/
`timescale 1ns/100ps
module ppp_port_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] data_bus,
  input wire logic load_clock,
  input wire logic action_bit0,
  input wire logic action_bit1,
  input wire logic byte_select_lo,
  input wire logic byte_select_hi,
  input wire logic program_strobe_n,
  input wire logic output_enable_n,
  input wire logic prog_voltage,
  input wire logic ready_busy_n,
  input wire logic dev_data_oe
);
  logic lc_r, lc_nxt;
  logic [7:0] cmd_r, cmd_nxt, low_r, low_nxt;
  logic [3:0] since_r, since_nxt;
  // command copy taken at the load_clock rise, as the device sees it
  always_comb begin
    lc_nxt = load_clock;
    cmd_nxt = cmd_r;
    if (load_clock && !lc_r && action_bit1 && !action_bit0) begin
      cmd_nxt = data_bus;
    end
    low_nxt = ready_busy_n ? 8'h00 : low_r + 8'(low_r != 8'hff);
    since_nxt = !program_strobe_n ? 4'h0 : since_r + 4'(since_r != 4'hf);
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lc_r <= 1'b0;
      cmd_r <= 8'h00;
      low_r <= 8'h00;
      since_r <= 4'hf;
    end else begin
      lc_r <= lc_nxt;
      cmd_r <= cmd_nxt;
      low_r <= low_nxt;
      since_r <= since_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_busy_len;
    $rose(ready_busy_n) |-> low_r inside {[63:67]};
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy span length wrong");
  property p_busy_cause;
    $fell(ready_busy_n) |-> since_r <= 4'h8;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without write strobe");
  property p_busy_hold;
    $fell(ready_busy_n) |-> !ready_busy_n [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_bus_release;
    output_enable_n [*5] |-> !dev_data_oe;
  endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("device drives bus without output enable");
  property p_bus_drive;
    $fell(output_enable_n) && prog_voltage |-> ##[1:5] dev_data_oe;
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("device does not drive bus on read");
  property p_erase_busy;
    $fell(program_strobe_n) && cmd_r == 8'h80 |-> ##[1:8] !ready_busy_n;
  endproperty
  a_erase_busy: assert property (p_erase_busy)
    else $error("erase strobe gave no busy");
  property p_page_busy;
    $fell(program_strobe_n) && (cmd_r == 8'h10 || cmd_r == 8'h11) &&
      !byte_select_hi && !byte_select_lo |-> ##[1:8] !ready_busy_n;
  endproperty
  a_page_busy: assert property (p_page_busy)
    else $error("page write strobe gave no busy");
  property p_read_cmd_idle;
    $fell(program_strobe_n) && cmd_r == 8'h04 |-> ready_busy_n [*8];
  endproperty
  a_read_cmd_idle: assert property (p_read_cmd_idle)
    else $error("read command started a write");
  property p_load_when_ready;
    $rose(load_clock) |-> ready_busy_n;
  endproperty
  a_load_when_ready: assert property (p_load_when_ready)
    else $error("load while busy");
endmodule : ppp_port_sva

// file: sim/test_parallel_program_port.sv
/*
  bench for both ends of the programming port joined by ppp_if.
  assumes the programmer runs entry by itself after reset.
*/
`timescale 1ns/100ps
`include "ppp_defines.svh"
`define CHECK_EQ(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_parallel_program_port;
  import ppp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic in_prog_mode, erase_done;
  logic [12:0] last_flash_page_addr;
  int err_count = 0;
  int checks_done = 0;
  int erase_cnt = 0;
  ppp_if ppp_if_i();
  ppp_device ppp_device_i(.core_clk(core_clk), .sys_rst(sys_rst),
    .pins(ppp_if_i), .in_prog_mode(in_prog_mode), .erase_done(erase_done),
    .last_flash_page_addr(last_flash_page_addr));
  ppp_programmer ppp_programmer_i(.core_clk(core_clk), .sys_rst(sys_rst),
    .pins(ppp_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ppp_port_sva ppp_port_sva_i(.core_clk(core_clk), .sys_rst(sys_rst),
    .data_bus(ppp_if_i.data_bus), .load_clock(ppp_if_i.load_clock),
    .action_bit0(ppp_if_i.action_bit0), .action_bit1(ppp_if_i.action_bit1),
    .byte_select_lo(ppp_if_i.byte_select_lo),
    .byte_select_hi(ppp_if_i.byte_select_hi),
    .program_strobe_n(ppp_if_i.program_strobe_n),
    .output_enable_n(ppp_if_i.output_enable_n),
    .prog_voltage(ppp_if_i.prog_voltage),
    .ready_busy_n(ppp_if_i.ready_busy_n), .dev_data_oe(ppp_if_i.dev_data_oe));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (erase_done === 1'b1) erase_cnt++;
  end
  task end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // tasks are entered just after a rising edge
  task reg_write(input logic [1:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [1:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : reg_read
  task wait_idle(input int n, output logic [15:0] s);
    int i;
    i = 0;
    s = 16'hffff;
    while (i < n && s[8] !== 1'b0) begin
      reg_read(2'h1, s);
      i++;
    end
    if (s[8] !== 1'b0) `CHECK_EQ("idle", 1'b0, s[8])
  endtask : wait_idle
  task op(input logic [1:0] o, input sel_t bs, input sel_t act,
      input byte_t d, output byte_t rb);
    logic [15:0] s;
    reg_write(2'h0, {2'b00, o, bs, act, d});
    repeat (2) @(posedge core_clk);
    wait_idle(400, s);
    rb = s[7:0];
  endtask : op
  task load(input sel_t act, input sel_t bs, input byte_t d);
    byte_t rb;
    op(2'd0, bs, act, d, rb);
  endtask : load
  task pulse(input logic [1:0] o, input sel_t bs);
    byte_t rb;
    op(o, bs, 2'h3, 8'h00, rb);
  endtask : pulse
  task read_chk(input sel_t bs, input byte_t e);
    byte_t rb;
    op(2'd3, bs, 2'h3, 8'h00, rb);
    `CHECK_EQ("read byte", e, rb)
  endtask : read_chk
  task t_fuse_defaults();
    int n;
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FUSE);
    read_chk(`BSEL_LO, `FUSE_LO_RST);
    read_chk(`BSEL_TOP, `FUSE_HI_RST);
    read_chk(`BSEL_EXT, `FUSE_EXT_RST);
    read_chk(`BSEL_HI, `LOCK_RST);
    n = erase_cnt;
    pulse(2'd2, `BSEL_LO);
    `CHECK_EQ("no erase", n, erase_cnt)
  endtask : t_fuse_defaults
  task t_lock_erase();
    int n;
    load(`ACT_CMD, `BSEL_LO, `CMD_WR_LOCK);
    load(`ACT_DATA, `BSEL_LO, 8'hfc);
    pulse(2'd2, `BSEL_LO);
    load(`ACT_CMD, `BSEL_LO, `CMD_WR_FUSE);
    load(`ACT_DATA, `BSEL_LO, 8'hf0);
    pulse(2'd2, `BSEL_EXT);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FUSE);
    read_chk(`BSEL_HI, 8'hfc);
    read_chk(`BSEL_EXT, 8'hf0);
    load(`ACT_CMD, `BSEL_LO, `CMD_ERASE);
    n = erase_cnt;
    pulse(2'd2, `BSEL_LO);
    `CHECK_EQ("erase done", n + 1, erase_cnt)
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FUSE);
    read_chk(`BSEL_HI, `LOCK_RST);
    read_chk(`BSEL_EXT, 8'hf0);
  endtask : t_lock_erase
  // only the low address byte is reloaded for the second page
  task t_pages();
    load(`ACT_CMD, `BSEL_LO, `CMD_WR_FLASH);
    load(`ACT_ADDR, `BSEL_LO, 8'h47);
    load(`ACT_ADDR, `BSEL_HI, 8'h01);
    load(`ACT_DATA, `BSEL_LO, 8'h34);
    load(`ACT_DATA, `BSEL_HI, 8'h12);
    pulse(2'd1, `BSEL_HI);
    pulse(2'd2, `BSEL_LO);
    `CHECK_EQ("flash page", 13'h0140, last_flash_page_addr)
    load(`ACT_ADDR, `BSEL_LO, 8'hc0);
    pulse(2'd1, `BSEL_HI);
    pulse(2'd2, `BSEL_LO);
    `CHECK_EQ("flash page 2", 13'h01c0, last_flash_page_addr)
    load(`ACT_CMD, `BSEL_LO, `CMD_WR_EEP);
    load(`ACT_ADDR, `BSEL_LO, 8'h06);
    load(`ACT_DATA, `BSEL_LO, 8'h5a);
    pulse(2'd1, `BSEL_LO);
    pulse(2'd2, `BSEL_LO);
    `CHECK_EQ("eeprom page", 13'h0104, last_flash_page_addr)
  endtask : t_pages
  // word 7 and eeprom byte 2 still hold what t_pages buffered
  task t_read_back();
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FLASH);
    load(`ACT_ADDR, `BSEL_LO, 8'h47);
    read_chk(`BSEL_LO, 8'h34);
    read_chk(`BSEL_HI, 8'h12);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_EEP);
    load(`ACT_ADDR, `BSEL_LO, 8'h06);
    read_chk(`BSEL_LO, 8'h5a);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_SIG);
    read_chk(`BSEL_LO, 8'h02);
    load(`ACT_CMD, `BSEL_LO, `CMD_WR_FUSE);
    load(`ACT_DATA, `BSEL_LO, 8'hd1);
    pulse(2'd2, `BSEL_HI);
    load(`ACT_CMD, `BSEL_LO, `CMD_ERASE);
    pulse(2'd2, `BSEL_LO);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FUSE);
    read_chk(`BSEL_TOP, 8'hd1);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_EEP);
    read_chk(`BSEL_LO, 8'h5a);
    load(`ACT_CMD, `BSEL_LO, `CMD_RD_FLASH);
    load(`ACT_ADDR, `BSEL_LO, 8'h47);
    read_chk(`BSEL_LO, 8'hff);
  endtask : t_read_back
  initial begin
    logic [15:0] s;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    wait_idle(8000, s);
    `CHECK_EQ("in mode", 1'b1, in_prog_mode)
    t_fuse_defaults();
    t_lock_erase();
    t_pages();
    t_read_back();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule : test_parallel_program_port
